// ### hw/udp_pkg.sv
package udp_pkg;

  // =========================================================================
  // widths and channel layout
  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned CH_W      = 8;
  localparam int unsigned BUS_W     = NUM_CH * CH_W;  // combined 32-bit path
  localparam int unsigned ADDR_W    = 6;

  // =========================================================================
  // register word offsets (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] REG_DATA   = 6'h00;  // +ch: out data / in bits
  localparam logic [ADDR_W-1:0] REG_DIR    = 6'h04;  // +ch: direction
  localparam logic [ADDR_W-1:0] REG_CTRL   = 6'h08;  // select, slopes, mode
  localparam logic [ADDR_W-1:0] REG_STAT   = 6'h09;  // sticky events
  localparam logic [ADDR_W-1:0] REG_MASK   = 6'h0a;  // interrupt mask
  localparam logic [ADDR_W-1:0] REG_HSK    = 6'h0b;  // live handshake state
  localparam logic [ADDR_W-1:0] REG_CMD    = 6'h0c;  // trigger, test, error
  localparam logic [ADDR_W-1:0] REG_CAP    = 6'h10;  // +ch: captured input

  // =========================================================================
  // control field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;  // 2 bits, selected channel
  localparam int unsigned CTRL_SLO_ACK  = 2;  // taken-ack edge, 1 = rising
  localparam int unsigned CTRL_SLO_IVS  = 3;  // input-valid edge, 1 = rising
  localparam int unsigned CTRL_DT_MODE  = 4;  // deferred-trigger mode
  localparam int unsigned CTRL_SLO_CH   = 5;  // slope bits go to this ch
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // status bits
  localparam int unsigned ST_OUT_TAKEN2 = 0;
  localparam int unsigned ST_OUT_TAKEN4 = 1;
  localparam int unsigned ST_IN_CAP2    = 2;
  localparam int unsigned ST_IN_CAP4    = 3;
  localparam int unsigned ST_TRIG       = 4;
  localparam int unsigned ST_W          = 5;

  // command bits
  localparam int unsigned CMD_GET       = 0;  // group execute trigger
  localparam int unsigned CMD_TEST      = 1;  // reset handshake lines
  localparam int unsigned CMD_ERR_SET   = 2;  // self-test fault found
  localparam int unsigned CMD_ERR_CLR   = 3;
  localparam int unsigned CMD_SELECT    = 4;  // host selected the card

  // =========================================================================
  // timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned ACTIVE_MS     = 20;
  localparam int unsigned ACTIVE_CYC    = (CLK_HZ / 1000) * ACTIVE_MS;
  localparam int unsigned SYSCLK_HZ     = 1_000_000;
  localparam int unsigned SYSCLK_HALF   = CLK_HZ / SYSCLK_HZ / 2;
  localparam int unsigned TRIG_CYC      = CLK_HZ / SYSCLK_HZ;  // 1 us pulse
  localparam int unsigned IACK_CYC      = CLK_HZ / SYSCLK_HZ;  // 1 us pulse

  // output handshake states
  typedef enum logic [1:0] {OH_IDLE, OH_VALID} out_hs_t;

endpackage : udp_pkg

// ### hw/edge_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser with rise/fall detection on agreeing stages
module edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // pin and result
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] sh_q;

  // =========================================================================
  // stage 0 is read only by stage 1
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= {sh_q[1:0], pin};
    end
  end

  assign level = sh_q[1];
  assign rise  = sh_q[1] & ~sh_q[2];
  assign fall  = ~sh_q[1] & sh_q[2];
endmodule : edge_sync

// ### hw/hs_channel.sv
`timescale 1ns/1ps
// handshake engine for one handshaked channel
module hs_channel (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control
  input  wire logic       data_load,
  input  wire logic       hs_clear,
  input  wire logic       ack_rise_sel,
  input  wire logic       ivs_rise_sel,
  input  wire logic [7:0] pin_data,
  // pins
  input  wire logic       output_taken_ack,
  input  wire logic       input_valid_strobe,
  output logic            output_valid_strobe_n,
  output logic            input_taken_ack_n,
  // results
  output logic [7:0]      cap_q,
  output logic            out_taken,
  output logic            in_cap
);
  udp_pkg::out_hs_t st_q;
  logic a_r, a_f, v_r, v_f, ack_ev, ivs_ev;
  logic [7:0] pin_s1_q, pin_s2_q;
  logic [4:0] iack_q;

  edge_sync u_ack (.clk(clk), .srst(srst), .pin(output_taken_ack),
                   .level(), .rise(a_r), .fall(a_f));
  edge_sync u_ivs (.clk(clk), .srst(srst), .pin(input_valid_strobe),
                   .level(), .rise(v_r), .fall(v_f));

  // programmed slope selects the recognised edge
  assign ack_ev = ack_rise_sel ? a_r : a_f;
  assign ivs_ev = ivs_rise_sel ? v_r : v_f;

  // =========================================================================
  // output side: valid held low until the taken edge
  always_ff @(posedge clk) begin
    if (srst || hs_clear) begin
      st_q <= udp_pkg::OH_IDLE;
    end else begin
      case (st_q)
        udp_pkg::OH_IDLE:  if (data_load) st_q <= udp_pkg::OH_VALID;
        udp_pkg::OH_VALID: if (ack_ev && !data_load) begin
          st_q <= udp_pkg::OH_IDLE;
        end
        default: st_q <= udp_pkg::OH_IDLE;
      endcase
    end
  end
  assign output_valid_strobe_n = (st_q != udp_pkg::OH_VALID);
  assign out_taken = (st_q == udp_pkg::OH_VALID) && ack_ev;

  // =========================================================================
  // data bits lag two stages, so they are taken when the edge shows
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      cap_q    <= 8'h00;
    end else begin
      pin_s1_q <= pin_data;
      pin_s2_q <= pin_s1_q;
      if (ivs_ev) cap_q <= pin_s2_q;
    end
  end
  assign in_cap = ivs_ev;

  // input-taken pulse, active low, one system clock long
  always_ff @(posedge clk) begin
    if (srst || hs_clear) begin
      iack_q <= 5'h00;
    end else if (ivs_ev) begin
      iack_q <= 5'(udp_pkg::IACK_CYC);
    end else if (iack_q != 5'h00) begin
      iack_q <= iack_q - 5'h01;
    end
  end
  assign input_taken_ack_n = (iack_q == 5'h00);

  a_valid_until_ack: assert property (@(posedge clk) disable iff (srst)
    (!output_valid_strobe_n && !ack_ev && !data_load && !hs_clear)
      |=> !output_valid_strobe_n)
    else $error("valid dropped before taken edge");
  a_iack_pulse: assert property (@(posedge clk) disable iff (srst)
    (ivs_ev && !hs_clear) |=> !input_taken_ack_n [*8])
    else $error("input taken pulse missing");
endmodule : hs_channel

// ### hw/user_ports.sv
`timescale 1ns/1ps
module user_ports (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // data pins, 32 bits, three signals per bit
  input  wire logic [31:0] port_channel_in,
  output logic [31:0]      port_channel_out,
  output logic [31:0]      port_channel_oe,
  // handshake pins, index 0 = channel 2, index 1 = channel 4
  input  wire logic [1:0]  output_taken_ack,
  input  wire logic [1:0]  input_valid_strobe,
  output logic [1:0]       output_valid_strobe_n,
  output logic [1:0]       input_taken_ack_n,
  // auxiliary outputs
  output logic             buffered_sys_clock,
  output logic             deferred_trigger_out,
  output logic             error_out,
  output logic             active_out,
  output logic             reset_out_n
);
  logic [31:0] dout_q, dir_q, ctrl_q, rd_d, rd_q;
  logic [udp_pkg::ST_W-1:0] stat_q, mask_q, ev;
  logic [1:0] ack_rise_q, ivs_rise_q, load_hs, taken, capd;
  logic [7:0] cap [2];
  logic [31:0] pin_s1_q, pin_s2_q;
  logic        ack_q, wr, err_q, dt_arm_q, trig_ev;
  logic [4:0]  sclk_cnt_q, trig_cnt_q;
  logic [19:0] act_cnt_q;
  logic        sclk_q, rst_done_q;
  logic [31:0] wmask;

  // byte enable mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // =========================================================================
  // bus: one wait cycle, answer on the second edge
  assign wr = avs_write && ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wmask = be_mask(avs_byteenable);

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // =========================================================================
  // data output and direction registers, byte per channel
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_q <= 32'h0000_0000;
      dir_q  <= 32'h0000_0000;  // all inputs after reset
    end else if (wr && avs_address[5:2] == udp_pkg::REG_DATA[5:2]) begin
      dout_q[avs_address[1:0]*8 +: 8] <= avs_writedata[7:0];
    end else if (wr && avs_address[5:2] == udp_pkg::REG_DIR[5:2]) begin
      dir_q[avs_address[1:0]*8 +: 8] <= avs_writedata[7:0];
    end
  end

  // bit drives pin only where direction is output; data sense free
  assign port_channel_out = dout_q;
  assign port_channel_oe  = dir_q;

  // data writes to channels 2 and 4 start a handshake
  assign load_hs[0] = wr && avs_address == (udp_pkg::REG_DATA + 6'h01);
  assign load_hs[1] = wr && avs_address == (udp_pkg::REG_DATA + 6'h03);

  // =========================================================================
  // control register; slope write targets the channel in ctrl bit 5
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q     <= udp_pkg::CTRL_RST;
      ack_rise_q <= 2'h0;  // falling edges after reset
      ivs_rise_q <= 2'h0;
    end else if (wr && avs_address == udp_pkg::REG_CTRL) begin
      ctrl_q <= avs_writedata & wmask;
      ack_rise_q[avs_writedata[udp_pkg::CTRL_SLO_CH]] <=
        avs_writedata[udp_pkg::CTRL_SLO_ACK];
      ivs_rise_q[avs_writedata[udp_pkg::CTRL_SLO_CH]] <=
        avs_writedata[udp_pkg::CTRL_SLO_IVS];
    end
  end

  // =========================================================================
  // two handshaked channels
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_hs
      hs_channel u_ch (
        .clk                   (clk),
        .srst                  (srst),
        .data_load             (load_hs[g]),
        .hs_clear              (wr && avs_address == udp_pkg::REG_CMD &&
                                avs_writedata[udp_pkg::CMD_TEST]),
        .ack_rise_sel          (ack_rise_q[g]),
        .ivs_rise_sel          (ivs_rise_q[g]),
        .pin_data              (port_channel_in[(2*g+1)*8 +: 8]),
        .output_taken_ack      (output_taken_ack[g]),
        .input_valid_strobe    (input_valid_strobe[g]),
        .output_valid_strobe_n (output_valid_strobe_n[g]),
        .input_taken_ack_n     (input_taken_ack_n[g]),
        .cap_q                 (cap[g]),
        .out_taken             (taken[g]),
        .in_cap                (capd[g])
      );
    end
  endgenerate

  // plain pin readback, two-stage synchronised
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 32'h0000_0000;
      pin_s2_q <= 32'h0000_0000;
    end else begin
      pin_s1_q <= port_channel_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // =========================================================================
  // deferred trigger: armed by mode, fired by trigger command
  assign trig_ev = wr && avs_address == udp_pkg::REG_CMD &&
                   avs_writedata[udp_pkg::CMD_GET] &&
                   ctrl_q[udp_pkg::CTRL_DT_MODE];
  always_ff @(posedge clk) begin
    if (srst) begin
      trig_cnt_q <= 5'h00;
    end else if (trig_ev) begin
      trig_cnt_q <= 5'(udp_pkg::TRIG_CYC);
    end else if (trig_cnt_q != 5'h00) begin
      trig_cnt_q <= trig_cnt_q - 5'h01;
    end
  end
  assign deferred_trigger_out = (trig_cnt_q != 5'h00);
  assign dt_arm_q = ctrl_q[udp_pkg::CTRL_DT_MODE];

  // =========================================================================
  // events: set wins over write-one clear
  assign ev = {trig_ev, capd[1], capd[0], taken[1], taken[0]};
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr && avs_address == udp_pkg::REG_STAT) begin
        stat_q <= (stat_q & ~avs_writedata[udp_pkg::ST_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (wr && avs_address == udp_pkg::REG_MASK) begin
        mask_q <= avs_writedata[udp_pkg::ST_W-1:0];
      end
    end
  end
  assign irq = |(stat_q & mask_q);

  // =========================================================================
  // error flag: a self-test fault sticks until cleared by software
  always_ff @(posedge clk) begin
    if (srst) begin
      err_q <= 1'b0;
    end else if (wr && avs_address == udp_pkg::REG_CMD) begin
      if (avs_writedata[udp_pkg::CMD_ERR_SET]) begin
        err_q <= 1'b1;
      end else if (avs_writedata[udp_pkg::CMD_ERR_CLR]) begin
        err_q <= 1'b0;
      end
    end
  end
  assign error_out = err_q;

  // activity stretch, retriggered by each select
  always_ff @(posedge clk) begin
    if (srst) begin
      act_cnt_q <= 20'h00000;
    end else if (wr && avs_address == udp_pkg::REG_CMD &&
                 avs_writedata[udp_pkg::CMD_SELECT]) begin
      act_cnt_q <= 20'(udp_pkg::ACTIVE_CYC);
    end else if (act_cnt_q != 20'h00000) begin
      act_cnt_q <= act_cnt_q - 20'h00001;
    end
  end
  assign active_out = (act_cnt_q != 20'h00000);

  // =========================================================================
  // 1 MHz system clock divided from 25 MHz; 25 is odd so duty is 12/25
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_cnt_q <= 5'h00;
      sclk_q     <= 1'b0;
    end else if (sclk_cnt_q == 5'(udp_pkg::TRIG_CYC - 1)) begin
      sclk_cnt_q <= 5'h00;
      sclk_q     <= 1'b0;
    end else begin
      sclk_cnt_q <= sclk_cnt_q + 5'h01;
      if (sclk_cnt_q == 5'(udp_pkg::SYSCLK_HALF)) sclk_q <= 1'b1;
    end
  end
  assign buffered_sys_clock = sclk_q;

  // reset output: low during reset, high after
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_done_q <= 1'b0;
    end else begin
      rst_done_q <= 1'b1;
    end
  end
  assign reset_out_n = rst_done_q;

  // =========================================================================
  // read mux, registered on the wait cycle
  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address[5:2] == udp_pkg::REG_DATA[5:2]) begin
      rd_d[7:0] = pin_s2_q[avs_address[1:0]*8 +: 8];
    end else if (avs_address[5:2] == udp_pkg::REG_DIR[5:2]) begin
      rd_d[7:0] = dir_q[avs_address[1:0]*8 +: 8];
    end else if (avs_address == udp_pkg::REG_CTRL) begin
      rd_d = ctrl_q;
    end else if (avs_address == udp_pkg::REG_STAT) begin
      rd_d[udp_pkg::ST_W-1:0] = stat_q;
    end else if (avs_address == udp_pkg::REG_MASK) begin
      rd_d[udp_pkg::ST_W-1:0] = mask_q;
    end else if (avs_address == udp_pkg::REG_HSK) begin
      rd_d[7:0] = {err_q, active_out, dt_arm_q, deferred_trigger_out,
                   input_taken_ack_n, output_valid_strobe_n};
    end else if (avs_address == (udp_pkg::REG_CAP + 6'h01)) begin
      rd_d[7:0] = cap[0];
    end else if (avs_address == (udp_pkg::REG_CAP + 6'h03)) begin
      rd_d[7:0] = cap[1];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rd_q <= rd_d;
    end
  end
  assign avs_readdata = rd_q;

  // =========================================================================
  a_trig_high: assert property (@(posedge clk) disable iff (srst)
    trig_ev |=> deferred_trigger_out [*8])
    else $error("trigger pulse not raised");
  a_active_hold: assert property (@(posedge clk) disable iff (srst)
    (wr && avs_address == udp_pkg::REG_CMD &&
     avs_writedata[udp_pkg::CMD_SELECT]) |=> active_out [*8])
    else $error("activity not held");
  a_err_sticky: assert property (@(posedge clk) disable iff (srst)
    (error_out && !(wr && avs_address == udp_pkg::REG_CMD)) |=> error_out)
    else $error("error flag dropped");
  a_err_follow: assert property (@(posedge clk) disable iff (srst)
    (wr && avs_address == udp_pkg::REG_CMD &&
     avs_writedata[udp_pkg::CMD_ERR_SET]) |=> error_out)
    else $error("error output not raised");
  a_reset_high: assert property (@(posedge clk)
    $fell(srst) |=> reset_out_n)
    else $error("reset output not high");
  a_clk_period: assert property (@(posedge clk) disable iff (srst)
    $rose(buffered_sys_clock) |-> ##25 $rose(buffered_sys_clock))
    else $error("system clock period wrong");
  a_dir_drive: assert property (@(posedge clk) disable iff (srst)
    port_channel_oe == dir_q)
    else $error("direction not applied");
  a_no_trig_off: assert property (@(posedge clk) disable iff (srst)
    (!deferred_trigger_out && !trig_ev) |=> !deferred_trigger_out)
    else $error("stray trigger");
endmodule : user_ports

// ### testbench/user_circuit.sv
`timescale 1ns/1ps
// ==========================================
// user circuit model on the breadboard side
module user_circuit (
  // clock
  input  wire logic        clk,
  // pins from the card
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [1:0]  valid_n,
  input  wire logic [1:0]  taken_n,
  // bench control
  input  wire logic [31:0] ext_data,
  input  wire logic [1:0]  idle_lvl,
  input  wire logic [1:0]  ivs_req,
  input  wire logic [7:0]  delay,
  // pins to the card
  output logic [31:0]      pin_in,
  output logic [1:0]       ack,
  output logic [1:0]       ivs
);
  logic [7:0] cnt_q [2] = '{8'h00, 8'h00};
  logic [1:0] busy_q = 2'b00;
  // driven bits read back, the rest come from outside
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_data);
  // idle level picks which edge the card sees first
  always @(posedge clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!valid_n[k]) begin  // seen inverted, positive-true
        cnt_q[k] <= cnt_q[k] + 8'h01;
        ack[k]   <= (cnt_q[k] >= delay) ^ idle_lvl[k];
      end else begin
        cnt_q[k] <= 8'h00;
        ack[k]   <= idle_lvl[k];
      end
      if (ivs_req[k]) busy_q[k] <= 1'b1;
      else if (!taken_n[k]) busy_q[k] <= 1'b0;
      ivs[k] <= (ivs_req[k] || busy_q[k]) ^ idle_lvl[k];
    end
  end
endmodule : user_circuit

// ### testbench/user_ports_tb.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the user data ports
module user_ports_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] ext_data = 32'h0;
  logic [1:0]  idle_lvl = 2'b01;  // ch2 idles high, ch4 low
  logic [1:0]  ivs_req = 2'b00;
  logic [7:0]  delay = 8'h20;
  logic [31:0] avs_readdata, pin_in, pin_out, pin_oe, rd, exp;
  logic        avs_waitrequest, irq, sys_clk, trig, err, act, rst_n, prev;
  logic [1:0]  ack, ivs, valid_n, taken_n;
  integer      seed = 32'h6685a42f;
  int          n_errors = 0, checks_done = 0, cycles = 0, i, k, n;

  always #20 clk = ~clk;
  // hang guard, well above the length of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  user_ports i_user_ports (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .port_channel_in(pin_in), .port_channel_out(pin_out),
    .port_channel_oe(pin_oe), .output_taken_ack(ack),
    .input_valid_strobe(ivs), .output_valid_strobe_n(valid_n),
    .input_taken_ack_n(taken_n), .buffered_sys_clock(sys_clk),
    .deferred_trigger_out(trig), .error_out(err), .active_out(act),
    .reset_out_n(rst_n));
  user_circuit i_user_circuit (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .valid_n(valid_n), .taken_n(taken_n), .ext_data(ext_data),
    .idle_lvl(idle_lvl), .ivs_req(ivs_req), .delay(delay),
    .pin_in(pin_in), .ack(ack), .ivs(ivs));

  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  function automatic logic pin_of(input int s);
    return s ? taken_n[k] : valid_n[k];
  endfunction : pin_of
  task automatic wait_pin(input int s, input logic lvl);
    for (i = 0; i < 200 && pin_of(s) !== lvl; i++) @(posedge clk);
    chk(s ? "taken_n" : "valid_n", 32'(lvl), 32'(pin_of(s)));
  endtask : wait_pin
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset_out_n", 32'h1, 32'(rst_n));
    chk("idle handshakes", 32'hf, {28'h0, taken_n, valid_n});
    bus(1'b0, 6'h3f, 32'h0);
    chk("unmapped", 32'h0, rd);
    // channel 1 only widens the path
    exp = $random(seed);
    bus(1'b1, udp_pkg::REG_DIR, 32'h5a);
    bus(1'b1, udp_pkg::REG_DATA, exp);
    @(posedge clk);
    chk("ch1 oe", 32'h5a, 32'(pin_oe[7:0]));
    chk("ch1 out", exp & 32'h5a, 32'(pin_out[7:0] & 8'h5a));
    bus(1'b0, udp_pkg::REG_DIR, 32'h0);
    chk("ch1 dir", 32'h5a, rd);
    bus(1'b0, udp_pkg::REG_DATA, 32'h0);
    chk("ch1 pins", exp & 32'h5a, rd);
    $display("done: channel 1");
    // ch2 on falling edges, ch4 on rising edges
    for (k = 0; k < 2; k++) begin
      idle_lvl[k] <= (k == 0);
      delay <= 8'h18 + 8'($random(seed) & 15);
      bus(1'b1, udp_pkg::REG_CTRL, k ? 32'h2c : 32'h00);
      bus(1'b1, 6'(udp_pkg::REG_DIR + 1 + 2 * k), 32'hff);
      exp = $random(seed);
      bus(1'b1, 6'(udp_pkg::REG_DATA + 1 + 2 * k), exp);
      wait_pin(0, 1'b0);
      chk("hs out", 32'(exp[7:0]), 32'(pin_out[8 + 16 * k +: 8]));
      repeat (20) @(posedge clk);
      chk("valid held", 32'h0, 32'(valid_n[k]));
      wait_pin(0, 1'b1);
      bus(1'b0, udp_pkg::REG_STAT, 32'h0);
      chk("stat taken", 32'h1 << k, rd & 32'h3);
      chk("irq masked", 32'h0, 32'(irq));
      bus(1'b1, udp_pkg::REG_MASK, 32'h1f);
      @(posedge clk);
      chk("irq", 32'h1, 32'(irq));
      bus(1'b1, udp_pkg::REG_STAT, 32'h1f);
      @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
      bus(1'b1, udp_pkg::REG_MASK, 32'h0);
      // input word handshake
      bus(1'b1, 6'(udp_pkg::REG_DIR + 1 + 2 * k), 32'h0);
      ext_data <= $random(seed);
      @(posedge clk);
      ivs_req[k] <= 1'b1;
      @(posedge clk);
      ivs_req[k] <= 1'b0;
      wait_pin(1, 1'b0);
      for (n = 0; n < 100 && taken_n[k] === 1'b0; n++) @(posedge clk);
      chk("taken width", udp_pkg::IACK_CYC, 32'(n));
      bus(1'b0, 6'(udp_pkg::REG_CAP + 1 + 2 * k), 32'h0);
      chk("capture", 32'(ext_data[8 + 16 * k +: 8]), rd);
      $display("done: handshake channel %0d", 2 + 2 * k);
    end
    // test command drops a pending output handshake
    bus(1'b1, 6'(udp_pkg::REG_DATA + 1), 32'h3c);
    @(posedge clk);
    chk("valid before test", 32'h0, 32'(valid_n[0]));
    bus(1'b1, udp_pkg::REG_CMD, 32'h2);
    @(posedge clk);
    chk("valid after test", 32'h1, 32'(valid_n[0]));
    $display("done: test command");
    // trigger fires only in deferred mode
    for (k = 0; k < 2; k++) begin
      bus(1'b1, udp_pkg::REG_CTRL, k ? 32'h10 : 32'h0);
      bus(1'b1, udp_pkg::REG_CMD, 32'h1);
      n = 0;
      repeat (60) begin
        @(posedge clk);
        n += (trig === 1'b1);
      end
      chk("trigger", k ? udp_pkg::TRIG_CYC : 32'h0, 32'(n));
    end
    bus(1'b1, udp_pkg::REG_CMD, 32'h4);
    @(posedge clk);
    chk("error set", 32'h1, 32'(err));
    bus(1'b1, udp_pkg::REG_CMD, 32'h8);
    @(posedge clk);
    chk("error clear", 32'h0, 32'(err));
    bus(1'b1, udp_pkg::REG_CMD, 32'h10);
    repeat (1000) @(posedge clk);
    chk("active", 32'h1, 32'(act));
    // ten rising edges of the 1 MHz copy in 250 cycles
    n = 0;
    prev = sys_clk;
    repeat (250) begin
      @(posedge clk);
      n += (sys_clk === 1'b1 && prev === 1'b0);
      prev = sys_clk;
    end
    chk("sys clock rises", 32'd10, 32'(n));
    $display("done: auxiliary outputs");
    give_verdict();
  end
endmodule : user_ports_tb
